// [src/dsmc_pkg.sv]
// Constants, command codes and timing shared by both ends of the sleep control link.
package dsmc_pkg;
	localparam logic [15:0] CMD_READ_DIAG   = 16'h0f00;
	localparam logic [15:0] CMD_READ_STATUS = 16'h0a00;
	localparam logic [15:0] CMD_SLEEP_ENTER = 16'h1000;
	localparam logic [15:0] CMD_SLEEP_EXIT  = 16'h1100;
	localparam int          CMD_BITS        = 16;
	localparam int          REPLY_BITS      = 8;
	localparam int          LOAD_OK_BIT     = 7;
	localparam int          FUNC_OK_BIT     = 6;
	localparam int          BOOSTER_BIT     = 7;
	localparam logic [7:0]  DIAG_RESET      = 8'h00;
	localparam int          CLK_MHZ         = 100;
	localparam int          SHUTDOWN_MS     = 120;
	localparam int          SHUTDOWN_CYC    = SHUTDOWN_MS * 1000 * CLK_MHZ;
	localparam int          WAKE_STEP_US    = 5000;
	localparam int          WAKE_STEP_CYC   = WAKE_STEP_US * CLK_MHZ;
	localparam int          GUARD_FRAMES    = 2;
	localparam int          SCLK_HALF_CYC   = 8;
	localparam int          FRAME_CYC       = 1666666;
	localparam int          LINE_CYC        = 1900;
	localparam int          TIMER_W         = 24;
	localparam logic [3:0]  HREG_CMD        = 4'h0;
	localparam logic [3:0]  HREG_STATUS     = 4'h1;
	localparam logic [3:0]  HREG_DIAG       = 4'h2;
	localparam logic [3:0]  HREG_DSTAT      = 4'h3;
	localparam logic [7:0]  HOP_ENTER       = 8'h01;
	localparam logic [7:0]  HOP_EXIT        = 8'h02;
	localparam logic [7:0]  HOP_DIAG        = 8'h03;
	localparam logic [7:0]  HOP_DSTAT       = 8'h04;
endpackage : dsmc_pkg

// [src/dsmc_link_if.sv]
// Serial command link and RGB sync lines between host and display device.
`timescale 1ns/10ps
`default_nettype none
interface dsmc_link_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;
	logic frame_sync;
	logic line_sync;
	modport device (input sclk, input cs_n, input mosi, input frame_sync, input line_sync,
		output miso);
	modport host (output sclk, output cs_n, output mosi, output frame_sync, output line_sync,
		input miso);
endinterface : dsmc_link_if
`default_nettype wire

// [src/dsmc_step_timer.sv]
// Down counter that times one step of a power sequence.
`timescale 1ns/10ps
`default_nettype none
module dsmc_step_timer #(
	parameter int W = dsmc_pkg::TIMER_W
) (
	input  wire logic         ref_clk,
	input  wire logic         sys_rst,
	input  wire logic         load,
	input  wire logic [W-1:0] value,
	output logic              done
);
	logic [W-1:0] cnt_q;
	logic         run_q;

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cnt_q <= '0;
			run_q <= 1'b0;
			done  <= 1'b0;
		end
		else if (load)
		begin
			cnt_q <= value;
			run_q <= 1'b1;
			done  <= 1'b0;
		end
		else
		begin
			done <= run_q && (cnt_q <= W'(1));
			if (run_q && (cnt_q <= W'(1)))
				run_q <= 1'b0;
			if (cnt_q != '0)
				cnt_q <= cnt_q - W'(1);
		end
	end
endmodule : dsmc_step_timer
`default_nettype wire

// [src/dsmc_device.sv]
// Display end: serial command slave, sleep entry and exit sequencer, status replies.
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module dsmc_device #(
	parameter int SHUTDOWN_CYC  = dsmc_pkg::SHUTDOWN_CYC,
	parameter int WAKE_STEP_CYC = dsmc_pkg::WAKE_STEP_CYC
) (
	input  wire logic      ref_clk,
	input  wire logic      sys_rst,
	dsmc_link_if.device    link,
	input  wire logic      load_ok_in,
	input  wire logic      func_ok_in,
	input  wire logic      dimming_req,
	output logic           dcdc_en,
	output logic           osc_en,
	output logic           scan_en,
	output logic           discharge,
	output logic           blank_force,
	output logic [1:0]     gate_ctrl,
	output logic           dimming_en,
	output logic           sleeping
);
	typedef enum logic [9:0] {
		S_SLEEP = 10'b0000000001,
		S_OSCON = 10'b0000000010,
		S_DCON  = 10'b0000000100,
		S_GATE  = 10'b0000001000,
		S_BLKO  = 10'b0000010000,
		S_AWAKE = 10'b0000100000,
		S_BLKI  = 10'b0001000000,
		S_DRAIN = 10'b0010000000,
		S_DCOFF = 10'b0100000000,
		S_OSCOF = 10'b1000000000
	} dsmc_state_t;

	localparam int TW = dsmc_pkg::TIMER_W;

	function automatic logic [TW-1:0] cyc(input int n);
		cyc = (n < 1) ? TW'(1) : TW'(n);
	endfunction : cyc

	logic [2:0]  sclk_s_q;
	logic [1:0]  cs_s_q;
	logic [1:0]  mosi_s_q;
	logic [15:0] rx_q;
	logic [4:0]  bit_q;
	logic        word_q;
	logic        load_pend_q;
	logic [7:0]  tx_q;
	logic [7:0]  reply_q;
	logic        miso_q;
	logic [7:0]  diag_q;
	logic        booster_q;
	dsmc_state_t state_q;
	dsmc_state_t state_d;
	logic        tmr_load;
	logic [TW-1:0] tmr_val;
	logic        tmr_done;
	logic        sclk_rise;
	logic        sclk_fall;
	logic        go_sleep;
	logic        go_wake;

	assign link.miso = miso_q;

	// Link pins pass two flops; edges are found on the synchronised copies only.
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sclk_s_q <= 3'h0;
			cs_s_q   <= 2'h3;
			mosi_s_q <= 2'h0;
		end
		else
		begin
			sclk_s_q <= {sclk_s_q[1:0], link.sclk};
			cs_s_q   <= {cs_s_q[0], link.cs_n};
			mosi_s_q <= {mosi_s_q[0], link.mosi};
		end
	end

	assign sclk_rise = sclk_s_q[1] && !sclk_s_q[2] && !cs_s_q[1];
	assign sclk_fall = !sclk_s_q[1] && sclk_s_q[2] && !cs_s_q[1];

	// Command word shifts in MSB first; the link stays live in every power state.
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rx_q   <= 16'h0000;
			bit_q  <= 5'h00;
			word_q <= 1'b0;
		end
		else
		begin
			word_q <= 1'b0;
			if (cs_s_q[1])
				bit_q <= 5'h00;
			else if (sclk_rise)
			begin
				if (bit_q < 5'(dsmc_pkg::CMD_BITS))
					rx_q <= {rx_q[14:0], mosi_s_q[1]};
				word_q <= (bit_q == 5'(dsmc_pkg::CMD_BITS - 1));
				bit_q  <= bit_q + 5'h01;
			end
		end
	end

	assign go_sleep = word_q && (rx_q == dsmc_pkg::CMD_SLEEP_ENTER);
	assign go_wake  = word_q && (rx_q == dsmc_pkg::CMD_SLEEP_EXIT);

	// Reply byte is chosen at the end of the command word and leaves on later falling edges.
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			load_pend_q <= 1'b0;
			reply_q     <= 8'h00;
			tx_q        <= 8'h00;
			miso_q      <= 1'b0;
		end
		else if (cs_s_q[1])
		begin
			load_pend_q <= 1'b0;
			miso_q      <= 1'b0;
		end
		else
		begin
			if (word_q && (rx_q == dsmc_pkg::CMD_READ_DIAG))
			begin
				load_pend_q <= 1'b1;
				reply_q     <= diag_q;
			end
			else if (word_q && (rx_q == dsmc_pkg::CMD_READ_STATUS))
			begin
				load_pend_q <= 1'b1;
				reply_q     <= 8'(booster_q) << dsmc_pkg::BOOSTER_BIT;
			end
			if (sclk_fall && load_pend_q)
			begin
				load_pend_q <= 1'b0;
				miso_q      <= reply_q[7];
				tx_q        <= {reply_q[6:0], 1'b0};
			end
			else if (sclk_fall)
			begin
				miso_q <= tx_q[7];
				tx_q   <= {tx_q[6:0], 1'b0};
			end
		end
	end

	// Diagnostic flags are taken when a wake sequence completes; the rest stays zero.
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			diag_q <= dsmc_pkg::DIAG_RESET;
		else if (state_q == S_BLKO && tmr_done)
		begin
			diag_q <= 8'h00;
			diag_q[dsmc_pkg::LOAD_OK_BIT] <= load_ok_in;
			diag_q[dsmc_pkg::FUNC_OK_BIT] <= func_ok_in;
		end
	end

	// Power sequencer: an enter or exit command starts its sequence at once; one given during its own sequence or in the state that sequence ends in is ignored.
	always_comb
	begin
		state_d  = state_q;
		tmr_load = 1'b0;
		tmr_val  = cyc(SHUTDOWN_CYC / 4);
		if (go_sleep && state_q != S_SLEEP &&
			state_q != S_BLKI && state_q != S_DRAIN &&
			state_q != S_DCOFF && state_q != S_OSCOF)
		begin
			state_d  = S_BLKI;
			tmr_load = 1'b1;
		end
		else if (go_wake && state_q != S_OSCON && state_q != S_DCON &&
			state_q != S_GATE && state_q != S_BLKO && state_q != S_AWAKE)
		begin
			state_d  = S_OSCON;
			tmr_load = 1'b1;
			tmr_val  = cyc(WAKE_STEP_CYC);
		end
		else if (tmr_done)
		begin
			tmr_load = 1'b1;
			tmr_val  = cyc(WAKE_STEP_CYC);
			case (state_q)
				S_OSCON: state_d = S_DCON;
				S_DCON:  state_d = S_GATE;
				S_GATE:  state_d = S_BLKO;
				S_BLKO:
				begin
					state_d  = S_AWAKE;
					tmr_load = 1'b0;
				end
				S_BLKI:
				begin
					state_d = S_DRAIN;
					tmr_val = cyc(SHUTDOWN_CYC / 4);
				end
				S_DRAIN:
				begin
					state_d = S_DCOFF;
					tmr_val = cyc(SHUTDOWN_CYC / 4);
				end
				S_DCOFF:
				begin
					state_d = S_OSCOF;
					tmr_val = cyc(SHUTDOWN_CYC - 3 * (SHUTDOWN_CYC / 4));
				end
				S_OSCOF:
				begin
					state_d  = S_SLEEP;
					tmr_load = 1'b0;
				end
				default:
				begin
					state_d  = state_q;
					tmr_load = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			state_q <= S_SLEEP;
		else
			state_q <= state_d;
	end

	// Blank periods are counted on the internal time base, not on the RGB sync lines.
	dsmc_step_timer #(
		.W     (TW)
	) u_timer (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.load    (tmr_load),
		.value   (tmr_val),
		.done    (tmr_done)
	);

	// Panel-facing controls follow the state of the next cycle so they come from flops.
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			osc_en      <= 1'b0;
			dcdc_en     <= 1'b0;
			scan_en     <= 1'b0;
			discharge   <= 1'b0;
			blank_force <= 1'b1;
			gate_ctrl   <= 2'h0;
			dimming_en  <= 1'b0;
			booster_q   <= 1'b0;
			sleeping    <= 1'b1;
		end
		else
		begin
			osc_en      <= (state_d != S_SLEEP);
			dcdc_en     <= !(state_d inside {S_SLEEP, S_OSCON, S_DCOFF, S_OSCOF});
			booster_q   <= !(state_d inside {S_SLEEP, S_OSCON, S_OSCOF});
			scan_en     <= (state_d inside {S_BLKO, S_AWAKE, S_BLKI});
			discharge   <= (state_d == S_DRAIN);
			blank_force <= (state_d != S_AWAKE);
			gate_ctrl   <= (state_d == S_GATE) ? 2'h1 :
				(state_d inside {S_BLKO, S_AWAKE, S_BLKI}) ? 2'h3 : 2'h0;
			dimming_en  <= (state_d == S_AWAKE) && dimming_req;
			if (state_q == S_OSCOF && state_d == S_SLEEP)
				sleeping <= 1'b1;
			else if (state_q == S_BLKO && state_d == S_AWAKE)
				sleeping <= 1'b0;
		end
	end
endmodule : dsmc_device
`default_nettype wire

// [src/dsmc_host.sv]
// Host end: register port, serial command master and RGB sync timing around sleep changes.
`timescale 1ns/10ps
`default_nettype none
module dsmc_host #(
	parameter int SHUTDOWN_CYC = dsmc_pkg::SHUTDOWN_CYC,
	parameter int FRAME_CYC    = dsmc_pkg::FRAME_CYC,
	parameter int LINE_CYC     = dsmc_pkg::LINE_CYC
) (
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	dsmc_link_if.host       link,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic [7:0]      reg_rdata
);
	typedef enum logic [3:0] {
		H_IDLE = 4'b0001,
		H_PRE  = 4'b0010,
		H_XFER = 4'b0100,
		H_POST = 4'b1000
	} dsmc_hstate_t;

	localparam int HALF = dsmc_pkg::SCLK_HALF_CYC;

	dsmc_hstate_t st_q;
	logic [15:0] cmd_q;
	logic [4:0]  nbits_q;
	logic [4:0]  bit_q;
	logic [7:0]  div_q;
	logic [7:0]  rx_q;
	logic [7:0]  diag_q;
	logic [7:0]  dstat_q;
	logic [7:0]  op_q;
	logic [23:0] wait_q;
	logic [1:0]  frames_q;
	logic [20:0] fcnt_q;
	logic [10:0] lcnt_q;
	logic        rgb_on_q;
	logic        sclk_q;
	logic        cs_n_q;
	logic        mosi_q;
	logic        fs_q;
	logic        ls_q;
	logic [1:0]  miso_s_q;
	logic        go;

	assign link.sclk       = sclk_q;
	assign link.cs_n       = cs_n_q;
	assign link.mosi       = mosi_q;
	assign link.frame_sync = fs_q;
	assign link.line_sync  = ls_q;
	assign go = reg_wr && (reg_addr == dsmc_pkg::HREG_CMD) && (st_q == H_IDLE);

	// RGB sync generator, free running while enabled.
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			fcnt_q <= '0;
			lcnt_q <= '0;
			fs_q   <= 1'b0;
			ls_q   <= 1'b0;
		end
		else
		begin
			fs_q <= rgb_on_q && (fcnt_q == 21'(FRAME_CYC - 1));
			ls_q <= rgb_on_q && (lcnt_q == 11'(LINE_CYC - 1));
			fcnt_q <= (!rgb_on_q || fcnt_q == 21'(FRAME_CYC - 1)) ? '0 : fcnt_q + 21'h1;
			lcnt_q <= (!rgb_on_q || lcnt_q == 11'(LINE_CYC - 1)) ? '0 : lcnt_q + 11'h1;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			miso_s_q <= 2'h0;
		else
			miso_s_q <= {miso_s_q[0], link.miso};
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_q <= H_IDLE;
			cmd_q <= 16'h0000;
			nbits_q <= 5'h00;
			bit_q <= 5'h00;
			div_q <= 8'h00;
			rx_q <= 8'h00;
			diag_q <= 8'h00;
			dstat_q <= 8'h00;
			op_q <= 8'h00;
			wait_q <= '0;
			frames_q <= 2'h0;
			rgb_on_q <= 1'b0;
			sclk_q <= 1'b0;
			cs_n_q <= 1'b1;
			mosi_q <= 1'b0;
		end
		else
		begin
			case (st_q)
				H_IDLE:
					if (go)
					begin
						op_q <= reg_wdata;
						nbits_q <= 5'(dsmc_pkg::CMD_BITS);
						frames_q <= 2'h0;
						case (reg_wdata)
							dsmc_pkg::HOP_ENTER: cmd_q <= dsmc_pkg::CMD_SLEEP_ENTER;
							dsmc_pkg::HOP_EXIT: cmd_q <= dsmc_pkg::CMD_SLEEP_EXIT;
							dsmc_pkg::HOP_DIAG: cmd_q <= dsmc_pkg::CMD_READ_DIAG;
							default: cmd_q <= dsmc_pkg::CMD_READ_STATUS;
						endcase
						if (reg_wdata == dsmc_pkg::HOP_DIAG || reg_wdata == dsmc_pkg::HOP_DSTAT)
							nbits_q <= 5'(dsmc_pkg::CMD_BITS + dsmc_pkg::REPLY_BITS);
						if (reg_wdata == dsmc_pkg::HOP_EXIT)
						begin
							rgb_on_q <= 1'b1;
							st_q <= H_PRE;
						end
						else
							st_q <= H_XFER;
					end
				H_PRE:
				begin
					if (fs_q)
						frames_q <= frames_q + 2'h1;
					if (fs_q && frames_q == 2'(dsmc_pkg::GUARD_FRAMES - 1))
						st_q <= H_XFER;
				end
				H_XFER:
				begin
					cs_n_q <= 1'b0;
					if (cs_n_q)
						mosi_q <= cmd_q[15];
					div_q <= (div_q == 8'(HALF - 1)) ? 8'h00 : div_q + 8'h01;
					if (!cs_n_q && div_q == 8'(HALF - 1))
					begin
						sclk_q <= !sclk_q;
						if (!sclk_q && bit_q >= 5'(dsmc_pkg::CMD_BITS))
							rx_q <= {rx_q[6:0], miso_s_q[1]};
						if (sclk_q)
						begin
							bit_q <= bit_q + 5'h01;
							cmd_q <= {cmd_q[14:0], 1'b0};
							mosi_q <= cmd_q[14];
							if (bit_q == nbits_q - 5'h01)
							begin
								cs_n_q <= 1'b1;
								bit_q <= 5'h00;
								wait_q <= 24'(SHUTDOWN_CYC);
								frames_q <= 2'h0;
								st_q <= (op_q == dsmc_pkg::HOP_ENTER) ? H_POST : H_IDLE;
								if (op_q == dsmc_pkg::HOP_DIAG)
									diag_q <= rx_q;
								if (op_q == dsmc_pkg::HOP_DSTAT)
									dstat_q <= rx_q;
							end
						end
					end
				end
				H_POST:
				begin
					if (fs_q && frames_q != 2'(dsmc_pkg::GUARD_FRAMES))
						frames_q <= frames_q + 2'h1;
					if (frames_q == 2'(dsmc_pkg::GUARD_FRAMES))
						rgb_on_q <= 1'b0;
					if (wait_q != '0)
						wait_q <= wait_q - 24'h1;
					else
					begin
						rgb_on_q <= 1'b0;
						st_q <= H_IDLE;
					end
				end
				default: st_q <= H_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			case (reg_addr)
				dsmc_pkg::HREG_STATUS: reg_rdata <= {6'h00, rgb_on_q, st_q != H_IDLE};
				dsmc_pkg::HREG_DIAG: reg_rdata <= diag_q;
				dsmc_pkg::HREG_DSTAT: reg_rdata <= dstat_q;
				default: reg_rdata <= 8'h00;
			endcase
		else
			reg_rdata <= 8'h00;
	end
endmodule : dsmc_host
`default_nettype wire

// [verification/dsmc_sva.sv]
// Assertions on the serial link and on the power outputs of the device end.
`timescale 1ns/10ps
`default_nettype none
module dsmc_sva (
	input wire logic       ref_clk,
	input wire logic       sys_rst,
	input wire logic       sclk,
	input wire logic       cs_n,
	input wire logic       miso,
	input wire logic       dcdc_en,
	input wire logic       osc_en,
	input wire logic       scan_en,
	input wire logic       discharge,
	input wire logic       blank_force,
	input wire logic [1:0] gate_ctrl,
	input wire logic       dimming_en,
	input wire logic       sleeping
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	miso_idle_a: assert property (cs_n [*6] |-> !miso)
		else $error("reply line driven outside a frame");
	sclk_idle_a: assert property (cs_n |-> !sclk)
		else $error("link clock moving outside a frame");
	asleep_off_a: assert property (sleeping && !osc_en |->
		!dcdc_en && !scan_en && gate_ctrl == 2'h0)
		else $error("power still on while asleep");
	no_dim_a: assert property (blank_force && $past(blank_force) |-> !dimming_en)
		else $error("dimming active during blanking");
	drain_order_a: assert property ($rose(discharge) |-> blank_force)
		else $error("drain started before blanking");
	dcdc_off_a: assert property ($fell(dcdc_en) |-> osc_en && blank_force)
		else $error("converter stopped out of order");
	osc_first_a: assert property ($rose(dcdc_en) |-> osc_en && $past(osc_en))
		else $error("converter started before oscillator");
	gate_seq_a: assert property ($changed(gate_ctrl) && gate_ctrl != 2'h0 |->
		dcdc_en && osc_en && $past(gate_ctrl) == (gate_ctrl == 2'h1 ? 2'h0 : 2'h1))
		else $error("gate control stepped out of order");
	wake_done_a: assert property ($fell(sleeping) |->
		dcdc_en && osc_en && scan_en && gate_ctrl == 2'h3)
		else $error("awake before start-up finished");
	sleep_done_a: assert property ($rose(sleeping) |->
		!dcdc_en && !osc_en && !scan_en && blank_force)
		else $error("asleep before shutdown finished");
	drain_power_a: assert property (discharge |-> dcdc_en && !scan_en && blank_force)
		else $error("panel drained with converter off or scanning");
	cover property ($rose(sleeping));
	cover property ($fell(sleeping));
	cover property ($fell(cs_n));
endmodule : dsmc_sva
`default_nettype wire

// [verification/test_display_sleep_mode_control.sv]
// Bench joining both ends, plus a second device end driven by hand.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
	$display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module test_display_sleep_mode_control;
	localparam int SD = 400;
	localparam int WS = 50;
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_rdata;
	logic        lo = 1'b0;
	logic        fo = 1'b0;
	logic        dim = 1'b0;
	logic        dcdc, osc, scan, dis, blank, dimo, slp, slp2;
	logic [1:0]  gate;
	logic [23:0] shf;
	logic [15:0] w_cmd;
	logic [7:0]  w_rep, rd, m_diag, r2;
	int          m_awake, fs0, err_total, n_checks, cyc, fs_cnt, fs_at_cs, nbit;
	int          seed = 32'hb8e98783;
	dsmc_link_if lk ();
	dsmc_link_if lk2 ();
	dsmc_host #(.SHUTDOWN_CYC(SD), .FRAME_CYC(200), .LINE_CYC(20)) u_dsmc_host (
		.ref_clk, .sys_rst, .link(lk.host), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata);
	dsmc_device #(.SHUTDOWN_CYC(SD), .WAKE_STEP_CYC(WS)) u_dsmc_device (
		.ref_clk, .sys_rst, .link(lk.device), .load_ok_in(lo), .func_ok_in(fo),
		.dimming_req(dim), .dcdc_en(dcdc), .osc_en(osc), .scan_en(scan),
		.discharge(dis), .blank_force(blank), .gate_ctrl(gate), .dimming_en(dimo),
		.sleeping(slp));
	// Second device end; the bench plays its host and never sends sync pulses.
	dsmc_device #(.SHUTDOWN_CYC(SD), .WAKE_STEP_CYC(WS)) u_dsmc_device_b (
		.ref_clk, .sys_rst, .link(lk2.device), .load_ok_in(lo), .func_ok_in(fo),
		.dimming_req(dim), .dcdc_en(), .osc_en(), .scan_en(), .discharge(),
		.blank_force(), .gate_ctrl(), .dimming_en(), .sleeping(slp2));
	dsmc_sva u_dsmc_sva (
		.ref_clk, .sys_rst, .sclk(lk.sclk), .cs_n(lk.cs_n), .miso(lk.miso),
		.dcdc_en(dcdc), .osc_en(osc), .scan_en(scan), .discharge(dis),
		.blank_force(blank), .gate_ctrl(gate), .dimming_en(dimo), .sleeping(slp));
	initial forever #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			err_total++;
			tally_and_finish();
		end
	end
	always @(negedge ref_clk)
		if (lk.frame_sync === 1'b1)
			fs_cnt++;
	always @(negedge lk.cs_n)
		fs_at_cs = fs_cnt;
	// Collects each frame as seen on the wire: command bits, then reply bits.
	always @(posedge lk.sclk)
	begin
		shf = {shf[22:0], nbit < 16 ? lk.mosi : lk.miso};
		nbit++;
	end
	always @(posedge lk.cs_n)
	begin
		w_cmd = nbit == 24 ? shf[23:8] : shf[15:0];
		w_rep = shf[7:0];
		nbit = 0;
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rdr(input logic [3:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rdr
	task automatic op(input logic [7:0] c);
		int k;
		wr(dsmc_pkg::HREG_CMD, c);
		k = 0;
		rd = 8'h01;
		while (rd[0] !== 1'b0 && k < 3000)
		begin
			rdr(dsmc_pkg::HREG_STATUS, rd);
			k++;
		end
		`CHK(rd[0], 1'b0)
	endtask : op
	task automatic wait_for(input bit b, input logic v, input int n);
		int k;
		k = 0;
		while ((b ? slp2 : slp) !== v && k < n)
		begin
			@(posedge ref_clk);
			#1;
			k++;
		end
	endtask : wait_for
	task automatic diag_chk();
		op(dsmc_pkg::HOP_DIAG);
		rdr(dsmc_pkg::HREG_DIAG, rd);
		`CHK(rd, m_diag)
		`CHK(w_rep, m_diag)
		`CHK(w_cmd, 16'h0f00)
	endtask : diag_chk
	task automatic dstat_chk();
		op(dsmc_pkg::HOP_DSTAT);
		rdr(dsmc_pkg::HREG_DSTAT, rd);
		`CHK(rd[7], m_awake[0])
		`CHK(w_cmd, 16'h0a00)
		`CHK(w_rep, {m_awake[0], 7'h00})
	endtask : dstat_chk
	task automatic spi2(input logic [15:0] w);
		int n;
		n = w == 16'h0f00 ? 24 : 16;
		lk2.cs_n <= 1'b0;
		for (int i = 0; i < n; i++)
		begin
			lk2.mosi <= i < 16 ? w[15 - i] : ~lk2.mosi;
			#62.5 lk2.sclk <= 1'b1;
			r2 = {r2[6:0], lk2.miso};
			#62.5 lk2.sclk <= 1'b0;
		end
		#62.5 lk2.cs_n <= 1'b1;
		lk2.mosi <= ~lk2.mosi;
		#200;
	endtask : spi2
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		lk2.sclk = 1'b0;
		lk2.cs_n = 1'b1;
		lk2.mosi = 1'b0;
		lk2.frame_sync = 1'b0;
		lk2.line_sync = 1'b0;
		m_diag = 8'h00;
		repeat (12) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		#1;
		`CHK({slp, blank, dcdc, osc, scan}, 5'h18)
		diag_chk();
		dstat_chk();
		op(dsmc_pkg::HOP_ENTER);
		`CHK(slp, 1'b1)
		for (int i = 0; i < 3; i++)
		begin
			@(posedge ref_clk);
			{lo, fo, dim} <= i == 2 ? 3'b111 : 3'($random(seed));
			fs0 = fs_cnt;
			op(dsmc_pkg::HOP_EXIT);
			`CHK(w_cmd, 16'h1100)
			`CHK(fs_at_cs - fs0 >= 2, 1'b1)
			`CHK(rd[1], 1'b1)
			wait_for(1'b0, 1'b0, 4 * WS + 20);
			m_awake = 1;
			m_diag = {lo, fo, 6'h00};
			`CHK({blank, dcdc, osc, scan, gate}, 6'h1f)
			@(posedge ref_clk);
			#1;
			`CHK(dimo, dim)
			wr(4'h7, dsmc_pkg::HOP_ENTER);
			diag_chk();
			dstat_chk();
			`CHK(slp, 1'b0)
			m_awake = 0;
			op(dsmc_pkg::HOP_ENTER);
			`CHK(w_cmd, 16'h1000)
			`CHK(rd[1], 1'b0)
			wait_for(1'b0, 1'b1, 40);
			`CHK({slp, dcdc, osc, scan, gate, dimo}, 7'h40)
			dstat_chk();
			diag_chk();
		end
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		m_diag = 8'h00;
		#1;
		`CHK(slp, 1'b1)
		diag_chk();
		spi2(16'h1200);
		wait_for(1'b1, 1'b0, 300);
		`CHK(slp2, 1'b1)
		spi2(16'h1100);
		`CHK(slp2, 1'b1)
		wait_for(1'b1, 1'b0, 4 * WS + 20);
		`CHK(slp2, 1'b0)
		spi2(16'h0f00);
		`CHK(r2, 8'hc0)
		spi2(16'h1000);
		`CHK(slp2, 1'b0)
		wait_for(1'b1, 1'b1, SD + 20);
		`CHK(slp2, 1'b1)
		tally_and_finish();
	end
endmodule : test_display_sleep_mode_control
`default_nettype wire
